// ==== grsb_bank.sv ====
/*
  Result and status bank of the battery gauge: charge, error margin, capacities,
  voltage, currents, temperature and two status words, read by command code.
  Assumes measurement results and event pulses come from the gauging logic
  synchronous to clk_sys, and that the serial slave presents one byte read per
  command strobe.
*/
// Summary of operation
// - charge percentage at 0x02, clamped 0-100
// - error margin at 0x03, kept 1-100
// - internal margin grows 0.05% per cycle count once a capacity update is seen
// - reported margin rises 1% per cycle count
// - reset 100, both 1, capacity 3, table 5
// - condition flag set above limit, cleared below
// - remaining capacity word at 0x04/0x05
// - full capacity word at 0x06/0x07
// - scaled flag indicates only, no scaling applied
// - voltage word at 0x08/0x09 in millivolts
// - average current at 0x0a, refreshed each second
// - temperature at 0x0c in tenth kelvin
// - source select: 0 internal, 1 external
// - main status high byte bit layout
// - main status low byte bit layout
// - open circuit bit: clear entry, set measured
// - full charge bit from termination or threshold
// - second status word layout at 0x12
// - first depth: set entry, clear valid/exit
// - instant current at 0x10, refreshed each second
// - voltage and temperature threshold status bits
`timescale 1ns/1ps
module grsb_bank
  import grsb_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES = REFRESH_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [7:0]        cmd_addr,
  input  wire logic              cmd_rd,
  input  wire logic              cmd_wr,
  input  wire logic [7:0]        cmd_wdata,
  output logic      [7:0]        rd_data,
  output logic                   rd_valid,
  input  wire logic [7:0]        charge_percent_in,
  input  wire logic [15:0]       capacity_left_in,
  input  wire logic [15:0]       capacity_full_in,
  input  wire logic [15:0]       voltage_in,
  input  wire logic [15:0]       avg_current_in,
  input  wire logic [15:0]       inst_current_in,
  input  wire logic [15:0]       temp_internal_in,
  input  wire logic [15:0]       temp_external_in,
  input  wire logic              temp_source_select,
  input  wire logic              scaled_units,
  input  wire logic [15:0]       cycle_counter,
  input  wire logic              qmax_update,
  input  wire logic              ra_update,
  input  wire logic [7:0]        error_limit,
  input  wire logic [15:0]       batt_high_mv,
  input  wire logic [15:0]       batt_low_mv,
  input  wire logic [15:0]       inhibit_temp_low,
  input  wire logic [15:0]       inhibit_temp_high,
  input  wire logic signed [7:0] full_set_threshold,
  input  wire logic              charge_termination,
  input  wire logic              relaxation_mode,
  input  wire logic              ocv_done,
  input  wire logic              dod_valid,
  input  wire logic              charge_overheat,
  input  wire logic              discharge_overheat,
  input  wire logic              charging_disallowed,
  input  wire logic              fast_charge_allowed,
  input  wire logic              charge_threshold_first,
  input  wire logic              charge_threshold_final,
  input  wire logic              discharge_detected,
  input  wire logic              health_calc_active,
  input  wire logic              iron_relaxation_mode_enabled,
  input  wire logic              end_charge_depth_updated,
  input  wire logic              capacity_temp_adjusted,
  output logic [11:0]            margin_fine,
  output logic                   scaled_units_seen
);

  typedef struct packed {
    logic [7:0]  charge;
    logic [7:0]  margin;
    logic [11:0] fine;
    logic        qmax_seen;
    logic [15:0] cap_left;
    logic [15:0] cap_full;
    logic [15:0] volt;
    logic [15:0] avg_cur;
    logic [15:0] inst_cur;
    logic [15:0] temp;
    logic [15:0] main_flags;
    logic [15:0] second_flags;
    logic [15:0] cycle_prev;
    logic        relaxation_mode_prev;
    logic [25:0] tick_cnt;
    logic [7:0]  rd_byte;
    logic        rd_ok;
  } grsb_state_type;

  grsb_state_type state_reg;
  grsb_state_type state_next;
  logic           tick;
  logic           cycle_step;
  logic           relaxation_mode_enter;
  logic           relaxation_mode_exit;

  function automatic logic [7:0] word_byte(input logic [15:0] w, input logic hi);
    word_byte = hi ? w[15:8] : w[7:0];
  endfunction

  assign tick        = (state_reg.tick_cnt == 26'(SECOND_CYCLES - 1));
  assign cycle_step  = (cycle_counter != state_reg.cycle_prev);
  assign relaxation_mode_enter = relaxation_mode && !state_reg.relaxation_mode_prev;
  assign relaxation_mode_exit  = !relaxation_mode && state_reg.relaxation_mode_prev;

  always_comb begin
    state_next = state_reg;
    state_next.cycle_prev = cycle_counter;
    state_next.relaxation_mode_prev = relaxation_mode;
    state_next.tick_cnt   = tick ? 26'h0 : state_reg.tick_cnt + 26'h1;

    if (charge_percent_in > PERCENT_FULL_SCALE) begin
      state_next.charge = PERCENT_FULL_SCALE;
    end else begin
      state_next.charge = charge_percent_in;
    end
    state_next.cap_left = capacity_left_in;
    state_next.cap_full = capacity_full_in;
    state_next.volt     = voltage_in;
    state_next.temp     = temp_source_select ? temp_external_in : temp_internal_in;
    if (tick) begin
      state_next.avg_cur  = avg_current_in;
      state_next.inst_cur = inst_current_in;
    end

    if (cycle_step) begin
      if (state_reg.margin < MARGIN_RESET) begin
        state_next.margin = state_reg.margin + 8'h01;
      end
      if (state_reg.qmax_seen && state_reg.fine < FINE_FULL_SCALE) begin
        state_next.fine = state_reg.fine + 12'h001;
      end
    end
    if (qmax_update && ra_update) begin
      state_next.margin = MARGIN_BOTH_UPDATE;
    end else if (qmax_update) begin
      state_next.margin = MARGIN_QMAX_UPDATE;
    end else if (ra_update) begin
      state_next.margin = MARGIN_RA_UPDATE;
    end
    if (qmax_update || ra_update) begin
      state_next.fine = 12'(state_next.margin * FINE_PER_PERCENT);
    end
    if (qmax_update) begin
      state_next.qmax_seen = 1'b1;
    end

    state_next.main_flags[BIT_CHARGE_OVERHEAT]     = charge_overheat;
    state_next.main_flags[BIT_DISCHARGE_OVERHEAT]  = discharge_overheat;
    state_next.main_flags[BIT_BATT_HIGH]           = voltage_in > batt_high_mv;
    state_next.main_flags[BIT_BATT_LOW]            = voltage_in < batt_low_mv;
    state_next.main_flags[BIT_CHARGE_INHIBITED]    =
      (state_next.temp < inhibit_temp_low) || (state_next.temp > inhibit_temp_high);
    state_next.main_flags[BIT_CHARGING_DISALLOWED] = charging_disallowed;
    state_next.main_flags[BIT_FAST_CHARGE_ALLOWED] = fast_charge_allowed;
    state_next.main_flags[BIT_THRESHOLD_FIRST]     = charge_threshold_first;
    state_next.main_flags[BIT_THRESHOLD_FINAL]     = charge_threshold_final;
    state_next.main_flags[BIT_DISCHARGE]           = discharge_detected;

    if (full_set_threshold == $signed(FULL_SET_DISABLED)) begin
      if (charge_termination) begin
        state_next.main_flags[BIT_FULL_CHARGE] = 1'b1;
      end else if (discharge_detected) begin
        state_next.main_flags[BIT_FULL_CHARGE] = 1'b0;
      end
    end else begin
      state_next.main_flags[BIT_FULL_CHARGE] =
        $signed({1'b0, state_reg.charge}) > 9'(full_set_threshold);
    end

    if (relaxation_mode_enter) begin
      state_next.main_flags[BIT_OCV_TAKEN] = 1'b0;
    end
    if (relaxation_mode && ocv_done) begin
      state_next.main_flags[BIT_OCV_TAKEN] = 1'b1;
    end

    if (state_reg.margin > error_limit) begin
      state_next.main_flags[BIT_CONDITION] = 1'b1;
    end else if (state_reg.margin < error_limit) begin
      state_next.main_flags[BIT_CONDITION] = 1'b0;
    end
    state_next.main_flags = state_next.main_flags & MAIN_USED_MASK;

    state_next.second_flags[BIT_HEALTH_ACTIVE]     = health_calc_active;
    state_next.second_flags[BIT_IRON_RELAXATION_MODE]        = iron_relaxation_mode_enabled;
    state_next.second_flags[BIT_END_CHARGE_DEPTH]  = end_charge_depth_updated;
    state_next.second_flags[BIT_CAP_TEMP_ADJUSTED] = capacity_temp_adjusted;
    if (dod_valid || relaxation_mode_exit) begin
      state_next.second_flags[BIT_FIRST_DEPTH] = 1'b0;
    end
    if (relaxation_mode_enter) begin
      state_next.second_flags[BIT_FIRST_DEPTH] = 1'b1;
    end
    state_next.second_flags = state_next.second_flags & SECOND_USED_MASK;

    // writes from the host are accepted by the slave but change nothing here
    state_next.rd_ok   = cmd_rd && !cmd_wr;
    state_next.rd_byte = RD_UNMAPPED;
    if (cmd_rd && !cmd_wr) begin
      unique case ({cmd_addr[7:1], 1'b0})
        CMD_CHARGE_PERCENT: begin
          state_next.rd_byte = cmd_addr[0] ? state_reg.margin : state_reg.charge;
        end
        CMD_CAPACITY_LEFT: state_next.rd_byte = word_byte(state_reg.cap_left, cmd_addr[0]);
        CMD_CAPACITY_FULL: state_next.rd_byte = word_byte(state_reg.cap_full, cmd_addr[0]);
        CMD_VOLTAGE:       state_next.rd_byte = word_byte(state_reg.volt, cmd_addr[0]);
        CMD_AVG_CURRENT:   state_next.rd_byte = word_byte(state_reg.avg_cur, cmd_addr[0]);
        CMD_TEMPERATURE:   state_next.rd_byte = word_byte(state_reg.temp, cmd_addr[0]);
        CMD_STATUS_MAIN:   state_next.rd_byte = word_byte(state_reg.main_flags, cmd_addr[0]);
        CMD_INST_CURRENT:  state_next.rd_byte = word_byte(state_reg.inst_cur, cmd_addr[0]);
        CMD_STATUS_SECOND: state_next.rd_byte = word_byte(state_reg.second_flags, cmd_addr[0]);
        default:           state_next.rd_byte = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg        <= '0;
      state_reg.margin <= MARGIN_RESET;
      state_reg.fine   <= FINE_FULL_SCALE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data           = state_reg.rd_byte;
  assign rd_valid          = state_reg.rd_ok;
  assign margin_fine       = state_reg.fine;
  assign scaled_units_seen = scaled_units;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_charge_range: assert property (state_reg.charge <= PERCENT_FULL_SCALE)
    else $error("charge percent above full scale");
  chk_margin_range: assert property (state_reg.margin >= 8'h01 && state_reg.margin <= MARGIN_RESET)
    else $error("error margin out of range");
  chk_margin_step: assert property (cycle_step && !qmax_update && !ra_update && state_reg.margin < MARGIN_RESET
    |=> state_reg.margin == $past(state_reg.margin) + 8'h01)
    else $error("reported margin did not rise by one");
  chk_fine_step: assert property (cycle_step && state_reg.qmax_seen && !qmax_update && !ra_update
    && state_reg.fine < FINE_FULL_SCALE |=> state_reg.fine == $past(state_reg.fine) + 12'h001)
    else $error("fine margin did not rise by one step");
  chk_margin_events: assert property (qmax_update |=> state_reg.margin == ($past(ra_update)
    ? MARGIN_BOTH_UPDATE : MARGIN_QMAX_UPDATE))
    else $error("margin not forced on capacity update");
  chk_margin_table: assert property (ra_update && !qmax_update |=> state_reg.margin == MARGIN_RA_UPDATE)
    else $error("margin not forced on table update");
  chk_cond_flag: assert property (state_reg.margin > error_limit ##1 $stable(error_limit)
    |-> state_reg.main_flags[BIT_CONDITION])
    else $error("condition flag not set above limit");
  chk_cond_clear: assert property (state_reg.margin < error_limit |=> !state_reg.main_flags[BIT_CONDITION])
    else $error("condition flag not cleared below limit");
  chk_ocv_set: assert property (relaxation_mode && ocv_done |=> state_reg.main_flags[BIT_OCV_TAKEN])
    else $error("open circuit bit not set on measurement");
  chk_current_tick: assert property (tick |=> state_reg.avg_cur == $past(avg_current_in)
    && state_reg.inst_cur == $past(inst_current_in) ##1 $stable(state_reg.avg_cur))
    else $error("current words not refreshed on the second");
  chk_reserved_zero: assert property ((state_reg.main_flags & ~MAIN_USED_MASK) == 16'h0000
    && (state_reg.second_flags & ~SECOND_USED_MASK) == 16'h0000)
    else $error("reserved status bit set");
  chk_ocv_entry: assert property (relaxation_mode_enter && !ocv_done |=> !state_reg.main_flags[BIT_OCV_TAKEN])
    else $error("open circuit bit not cleared on relaxation entry");
  chk_first_depth: assert property (relaxation_mode_enter |=> state_reg.second_flags[BIT_FIRST_DEPTH])
    else $error("first depth bit not set on relaxation entry");
  chk_full_term: assert property (charge_termination && full_set_threshold == -8'sd1
    |=> state_reg.main_flags[BIT_FULL_CHARGE])
    else $error("full charge bit not set on termination");
  chk_temp_select: assert property (!reset |=> state_reg.temp == ($past(temp_source_select)
    ? $past(temp_external_in) : $past(temp_internal_in)))
    else $error("temperature source select wrong");
  chk_read_turn: assert property (cmd_rd && !cmd_wr |=> rd_valid ##1 !$past(cmd_rd) |-> !rd_valid)
    else $error("read answer timing wrong");

  cov_both_update: cover property (qmax_update && ra_update ##1 state_reg.margin == MARGIN_BOTH_UPDATE);
  cov_cond_set:    cover property ($rose(state_reg.main_flags[BIT_CONDITION]));
  cov_relaxation_mode_ocv:   cover property (relaxation_mode_enter ##[1:20] ocv_done && relaxation_mode);
  cov_status_read: cover property (cmd_rd && cmd_addr == CMD_STATUS_MAIN ##1 rd_valid);

endmodule

// ==== grsb_host.sv ====
/*
  Host model for the result and status bank: issues byte reads and writes on the
  command port, one request at a time.
  Assumes the bank takes a request at a rising clk_sys edge and answers one cycle later.
*/
`timescale 1ns/1ps
module grsb_host (
  input  wire logic       clk_sys,
  output logic      [7:0] cmd_addr,
  output logic            cmd_rd,
  output logic            cmd_wr,
  output logic      [7:0] cmd_wdata,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial begin
    cmd_addr = 8'h00;
    cmd_rd = 1'b0;
    cmd_wr = 1'b0;
    cmd_wdata = 8'h00;
  end

  // address is inverted once released so a stale value never looks valid
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    cmd_rd <= 1'b1;
    cmd_addr <= a;
    @(posedge clk_sys);
    cmd_rd <= 1'b0;
    cmd_addr <= ~a;
    // the answer stands from the taking edge to the next one
    #1;
    v = rd_valid;
    d = rd_data;
  endtask

  // read strobe raised with the write one: must not count as a read
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cmd_wr <= 1'b1;
    cmd_rd <= 1'b1;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    cmd_addr <= ~a;
    cmd_wdata <= ~d;
  endtask
endmodule

// ==== grsb_pkg.sv ====
/*
  Package for the gauge result and status bank: command codes, flag bit positions,
  error margin settings and timing constants.
  Assumes a single 40 MHz system clock and byte-wide command addressing.
*/
package grsb_pkg;
  // command codes (byte addresses seen by the serial slave)
  localparam logic [7:0] CMD_CHARGE_PERCENT = 8'h02;
  localparam logic [7:0] CMD_ERROR_MARGIN   = 8'h03;
  localparam logic [7:0] CMD_CAPACITY_LEFT  = 8'h04;
  localparam logic [7:0] CMD_CAPACITY_FULL  = 8'h06;
  localparam logic [7:0] CMD_VOLTAGE        = 8'h08;
  localparam logic [7:0] CMD_AVG_CURRENT    = 8'h0a;
  localparam logic [7:0] CMD_TEMPERATURE    = 8'h0c;
  localparam logic [7:0] CMD_STATUS_MAIN    = 8'h0e;
  localparam logic [7:0] CMD_INST_CURRENT   = 8'h10;
  localparam logic [7:0] CMD_STATUS_SECOND  = 8'h12;
  localparam logic [7:0] RD_UNMAPPED        = 8'h00;

  // main status word bit positions
  localparam int BIT_CHARGE_OVERHEAT     = 15;
  localparam int BIT_DISCHARGE_OVERHEAT  = 14;
  localparam int BIT_BATT_HIGH           = 13;
  localparam int BIT_BATT_LOW            = 12;
  localparam int BIT_CHARGE_INHIBITED    = 11;
  localparam int BIT_CHARGING_DISALLOWED = 10;
  localparam int BIT_FULL_CHARGE         = 9;
  localparam int BIT_FAST_CHARGE_ALLOWED = 8;
  localparam int BIT_OCV_TAKEN           = 7;
  localparam int BIT_CONDITION           = 4;
  localparam int BIT_THRESHOLD_FIRST     = 2;
  localparam int BIT_THRESHOLD_FINAL     = 1;
  localparam int BIT_DISCHARGE           = 0;
  localparam logic [15:0] MAIN_USED_MASK = 16'hff97;

  // second status word bit positions
  localparam int BIT_HEALTH_ACTIVE       = 15;
  localparam int BIT_IRON_RELAXATION_MODE          = 14;
  localparam int BIT_FIRST_DEPTH         = 13;
  localparam int BIT_END_CHARGE_DEPTH    = 10;
  localparam int BIT_CAP_TEMP_ADJUSTED   = 9;
  localparam logic [15:0] SECOND_USED_MASK = 16'he600;

  // charge percentage and error margin figures, in percent
  localparam logic [7:0] PERCENT_FULL_SCALE = 8'h64;
  localparam logic [7:0] MARGIN_RESET       = 8'h64;
  localparam logic [7:0] MARGIN_BOTH_UPDATE = 8'h01;
  localparam logic [7:0] MARGIN_QMAX_UPDATE = 8'h03;
  localparam logic [7:0] MARGIN_RA_UPDATE   = 8'h05;
  // fine margin counts in steps of 0.05 percent
  localparam logic [11:0] FINE_PER_PERCENT = 12'h014;
  localparam logic [11:0] FINE_FULL_SCALE  = 12'h7d0;
  localparam logic [7:0] FULL_SET_DISABLED = 8'hff;

  // refresh interval of the current words
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned REFRESH_PERIOD_MS = 1000;
  localparam int unsigned REFRESH_CYCLES    = CLK_HZ / 1000 * REFRESH_PERIOD_MS;
endpackage

// ==== testbench.sv ====
/*
  Self-checking testbench of the result and status bank: byte and word reads through
  the host model, event pulses and level inputs from the bench.
  Assumes a 40 MHz clock and a shortened one-second tick of 8 cycles.
*/
`timescale 1ns/1ps
module testbench;
  import grsb_pkg::*;
  logic              clk_sys = 1'b0;
  logic              reset = 1'b1;
  logic [7:0]        cmd_addr, cmd_wdata, rd_data, charge_percent_in, error_limit;
  logic              cmd_rd, cmd_wr, rd_valid, temp_source_select, scaled_units, qmax_update, ra_update;
  logic              charge_termination, relaxation_mode, ocv_done, dod_valid, charge_overheat;
  logic              discharge_overheat, charging_disallowed, fast_charge_allowed, charge_threshold_first;
  logic              charge_threshold_final, discharge_detected, health_calc_active, iron_relaxation_mode_enabled;
  logic              end_charge_depth_updated, capacity_temp_adjusted, scaled_units_seen;
  logic [15:0]       capacity_left_in, capacity_full_in, voltage_in, avg_current_in, inst_current_in;
  logic [15:0]       temp_internal_in, temp_external_in, cycle_counter, batt_high_mv, batt_low_mv;
  logic [15:0]       inhibit_temp_low, inhibit_temp_high;
  logic signed [7:0] full_set_threshold;
  logic [11:0]       margin_fine;
  int                n_mismatch = 0;
  int                comparisons = 0;

  always #12.5 clk_sys = ~clk_sys;

  grsb_host host (.clk_sys, .cmd_addr, .cmd_rd, .cmd_wr, .cmd_wdata, .rd_data, .rd_valid);

  grsb_bank #(.SECOND_CYCLES(8)) dut (
    .clk_sys, .reset, .cmd_addr, .cmd_rd, .cmd_wr, .cmd_wdata, .rd_data, .rd_valid, .charge_percent_in,
    .capacity_left_in, .capacity_full_in, .voltage_in, .avg_current_in, .inst_current_in, .temp_internal_in,
    .temp_external_in, .temp_source_select, .scaled_units, .cycle_counter, .qmax_update, .ra_update,
    .error_limit, .batt_high_mv, .batt_low_mv, .inhibit_temp_low, .inhibit_temp_high, .full_set_threshold,
    .charge_termination, .relaxation_mode, .ocv_done, .dod_valid, .charge_overheat, .discharge_overheat,
    .charging_disallowed, .fast_charge_allowed, .charge_threshold_first, .charge_threshold_final,
    .discharge_detected, .health_calc_active, .iron_relaxation_mode_enabled, .end_charge_depth_updated,
    .capacity_temp_adjusted, .margin_fine, .scaled_units_seen);

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // valid flag rides in the upper byte of the compare
  task automatic byte_is(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.read_byte(a, d, v);
    check(what, {8'h01, exp}, {7'h00, v, d});
  endtask

  task automatic rd_word(input logic [7:0] a, output logic [15:0] w);
    logic [7:0] lo, hi;
    logic       vl, vh;
    host.read_byte(a, lo, vl);
    host.read_byte(a + 8'h01, hi, vh);
    w = {hi, lo};
    check("answer valid", 16'h0001, {15'h0000, vl & vh});
  endtask

  task automatic word_is(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] w;
    rd_word(a, w);
    check(what, exp, w);
  endtask

  task automatic bit_is(input string what, input logic [7:0] a, input int b, input logic exp);
    logic [15:0] w;
    rd_word(a, w);
    check(what, {15'h0000, exp}, {15'h0000, w[b]});
  endtask

  task automatic fine_is(input logic [11:0] exp);
    @(posedge clk_sys);
    #1;
    check("margin_fine", {4'h0, exp}, {4'h0, margin_fine});
  endtask

  task automatic margin_event(input logic q, input logic r);
    @(posedge clk_sys);
    qmax_update <= q;
    ra_update <= r;
    @(posedge clk_sys);
    qmax_update <= 1'b0;
    ra_update <= 1'b0;
  endtask

  task automatic bump_cycle;
    @(posedge clk_sys);
    cycle_counter <= cycle_counter + 16'h0001;
  endtask

  task automatic give_verdict;
    $display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    {qmax_update, ra_update, charge_termination, relaxation_mode, ocv_done, dod_valid, scaled_units} = 7'h00;
    {charge_overheat, discharge_overheat, charging_disallowed, fast_charge_allowed} = 4'h0;
    {charge_threshold_first, charge_threshold_final, discharge_detected, health_calc_active} = 4'h0;
    {iron_relaxation_mode_enabled, end_charge_depth_updated, capacity_temp_adjusted} = 3'h0;
    temp_source_select = 1'b1;
    charge_percent_in = 8'h96;
    error_limit = 8'h64;
    full_set_threshold = 8'sh14;
    {capacity_left_in, capacity_full_in, voltage_in} = {16'h1a2b, 16'h3c4d, 16'hfedc};
    {avg_current_in, inst_current_in, cycle_counter} = {16'h8001, 16'h7ffe, 16'h0000};
    {temp_internal_in, temp_external_in} = {16'h0bb8, 16'h0c1c};
    {batt_high_mv, batt_low_mv, inhibit_temp_low, inhibit_temp_high} = {16'h1000, 16'h0100, 16'h0000, 16'hffff};
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    byte_is("margin after reset", CMD_ERROR_MARGIN, MARGIN_RESET);
    bump_cycle();
    byte_is("margin saturated", CMD_ERROR_MARGIN, MARGIN_RESET);
    fine_is(FINE_FULL_SCALE);
    $display("test reset done");
    byte_is("charge clamped", CMD_CHARGE_PERCENT, PERCENT_FULL_SCALE);
    @(posedge clk_sys) charge_percent_in <= 8'h2a;
    byte_is("charge", CMD_CHARGE_PERCENT, 8'h2a);
    word_is("capacity left", CMD_CAPACITY_LEFT, 16'h1a2b);
    word_is("capacity full", CMD_CAPACITY_FULL, 16'h3c4d);
    word_is("voltage", CMD_VOLTAGE, 16'hfedc);
    word_is("average current", CMD_AVG_CURRENT, 16'h8001);
    word_is("instant current", CMD_INST_CURRENT, 16'h7ffe);
    word_is("external temp", CMD_TEMPERATURE, 16'h0c1c);
    @(posedge clk_sys) temp_source_select <= 1'b0;
    @(posedge clk_sys) scaled_units <= 1'b1;
    word_is("internal temp", CMD_TEMPERATURE, 16'h0bb8);
    word_is("capacity unscaled", CMD_CAPACITY_FULL, 16'h3c4d);
    check("scaled echo", 16'h0001, {15'h0000, scaled_units_seen});
    byte_is("unmapped", 8'h20, 8'h00);
    host.write_byte(CMD_CHARGE_PERCENT, 8'h55);
    repeat (2) begin
      #1;
      check("write answered", 16'h0000, {15'h0000, rd_valid});
      @(posedge clk_sys);
    end
    byte_is("charge after write", CMD_CHARGE_PERCENT, 8'h2a);
    $display("test words done");
    @(posedge clk_sys);
    {charge_overheat, charging_disallowed, charge_threshold_first, discharge_detected} <= 4'hf;
    {health_calc_active, end_charge_depth_updated} <= 2'h3;
    word_is("main status a", CMD_STATUS_MAIN, 16'ha605);
    word_is("second status a", CMD_STATUS_SECOND, 16'h8400);
    @(posedge clk_sys);
    {charge_overheat, charging_disallowed, charge_threshold_first, discharge_detected} <= 4'h0;
    {health_calc_active, end_charge_depth_updated, iron_relaxation_mode_enabled, capacity_temp_adjusted} <= 4'h3;
    {discharge_overheat, fast_charge_allowed, charge_threshold_final} <= 3'h7;
    {batt_high_mv, batt_low_mv, inhibit_temp_high} <= {16'hffff, 16'hffff, 16'h0100};
    full_set_threshold <= 8'sh32;
    word_is("main status b", CMD_STATUS_MAIN, 16'h5902);
    word_is("second status b", CMD_STATUS_SECOND, 16'h4200);
    @(posedge clk_sys) full_set_threshold <= -8'sd1;
    @(posedge clk_sys) charge_termination <= 1'b1;
    @(posedge clk_sys) charge_termination <= 1'b0;
    bit_is("full on termination", CMD_STATUS_MAIN, BIT_FULL_CHARGE, 1'b1);
    @(posedge clk_sys) discharge_detected <= 1'b1;
    bit_is("full cleared", CMD_STATUS_MAIN, BIT_FULL_CHARGE, 1'b0);
    $display("test status done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys) relaxation_mode <= 1'b1;
      bit_is("depth on entry", CMD_STATUS_SECOND, BIT_FIRST_DEPTH, 1'b1);
      bit_is("ocv on entry", CMD_STATUS_MAIN, BIT_OCV_TAKEN, 1'b0);
      @(posedge clk_sys) ocv_done <= 1'b1;
      @(posedge clk_sys) ocv_done <= 1'b0;
      bit_is("ocv measured", CMD_STATUS_MAIN, BIT_OCV_TAKEN, 1'b1);
      if (i == 0) begin
        @(posedge clk_sys) dod_valid <= 1'b1;
        @(posedge clk_sys) dod_valid <= 1'b0;
        bit_is("depth on valid", CMD_STATUS_SECOND, BIT_FIRST_DEPTH, 1'b0);
      end
      @(posedge clk_sys) relaxation_mode <= 1'b0;
      bit_is("depth cleared", CMD_STATUS_SECOND, BIT_FIRST_DEPTH, 1'b0);
    end
    $display("test relaxation done");
    @(posedge clk_sys) error_limit <= 8'h05;
    margin_event(1'b0, 1'b1);
    byte_is("margin table", CMD_ERROR_MARGIN, MARGIN_RA_UPDATE);
    fine_is(12'h064);
    // margin was above the limit before the update, so at the limit the flag holds
    bit_is("condition at limit", CMD_STATUS_MAIN, BIT_CONDITION, 1'b1);
    bump_cycle();
    byte_is("margin plus one", CMD_ERROR_MARGIN, 8'h06);
    fine_is(12'h064);
    bit_is("condition above", CMD_STATUS_MAIN, BIT_CONDITION, 1'b1);
    margin_event(1'b1, 1'b0);
    byte_is("margin capacity", CMD_ERROR_MARGIN, MARGIN_QMAX_UPDATE);
    bit_is("condition below", CMD_STATUS_MAIN, BIT_CONDITION, 1'b0);
    bump_cycle();
    byte_is("margin after learn", CMD_ERROR_MARGIN, 8'h04);
    fine_is(12'h03d);
    margin_event(1'b1, 1'b1);
    byte_is("margin both", CMD_ERROR_MARGIN, MARGIN_BOTH_UPDATE);
    fine_is(FINE_PER_PERCENT);
    $display("test margin done");
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    give_verdict();
  end
endmodule
